// ---- common/serial_tx_defs.vh ----
// register offsets, field positions and timing constants of the serial transmitter
`ifndef SERIAL_TX_DEFS_VH
`define SERIAL_TX_DEFS_VH

// register byte addresses
`define OFF_TX_STATUS_CONTROL 12'h000
`define OFF_RX_STATUS_CONTROL 12'h004
`define OFF_BAUD_CONTROL      12'h008
`define OFF_RECEIVE_DATA      12'h00C
`define OFF_TRANSMIT_DATA     12'h010
`define OFF_BAUD_DIV_LOW      12'h014
`define OFF_BAUD_DIV_HIGH     12'h018
`define OFF_IRQ_CONTROL       12'h01C
`define OFF_IRQ_STATUS        12'h020
`define OFF_IRQ_MASK          12'h024

// transmit_status_control fields
`define TSC_SYNC_MODE         4
`define TSC_TRANSMITTER_ON    5
`define TSC_NINE_BIT_SELECT   6
`define TSC_HIGH_SPEED_BAUD   2
`define TSC_SHIFT_EMPTY       1
`define TSC_NINTH_DATA_BIT    0
`define TSC_WRITE_MASK        8'hFD

// receive_status_control fields
`define RSC_PORT_ENABLE       7
`define RSC_WRITE_MASK        8'h80

// baud_control fields
`define BCN_OUTPUT_POLARITY   4
`define BCN_WIDE_BAUD         3
`define BCN_WRITE_MASK        8'h18

// interrupt_control fields
`define ICN_GLOBAL_IRQ_ENABLE 0
`define ICN_PERIPH_IRQ_ENABLE 1
`define ICN_TX_IRQ_ENABLE     2
`define ICN_WRITE_MASK        8'h07

// sticky event bits
`define EVT_HOLDING_FREE      0
`define EVT_FRAME_DONE        1
`define EVT_WIDTH             2

// shifter frame: start + 9 data + stop
`define FRAME_BITS_8          4'd10
`define FRAME_BITS_9          4'd11
`define SHIFT_WIDTH           11
`define BIT_CNT_ZERO          4'h0
`define DIV_ZERO              16'h0000

// register reset values
`define RST_BYTE              8'h00

`endif

// ---- logic/async_serial_transmitter.v ----
// apb-attached asynchronous serial transmitter with holding and shift registers
`timescale 1ns/100ps
`include "serial_tx_defs.vh"

// Overview of operation
// - shift-empty bit reads one while shifter holds no character
// - shift-empty clears on load, stays clear until last bit leaves
// - shift-empty bit raises no interrupt; software must poll
// - shifter has no register address; software cannot reach it
// - nine-bit select shifts nine data bits per character
// - in nine-bit mode, holding load moves all nine bits into shifter at once
// - in nine-bit mode a set ninth bit marks an address byte
// - polarity bit set inverts the serial output
// - setting transmitter enable sets the transmit interrupt flag
// - flag with irq, global and peripheral enables requests interrupt
// - writing holding register starts transmission when enabled
// - unimplemented register bits read as zero, except transmit status bits 7 and 3, which read back as written
module async_serial_transmitter (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // serial line
  output reg         tx_out,
  // interrupts
  output reg         tx_irq,
  output reg         irq
);

  reg  [7:0]  tsc_r;
  reg  [7:0]  rsc_r;
  reg  [7:0]  bcn_r;
  reg  [7:0]  icn_r;
  reg  [7:0]  div_lo_r;
  reg  [7:0]  div_hi_r;
  reg  [7:0]  hold_r;
  reg         hold_ninth_r;
  reg         hold_full_r;
  reg  [`SHIFT_WIDTH-1:0] shifter_r;
  reg  [3:0]  bits_left_r;
  reg  [15:0] baud_cnt_r;
  reg  [`EVT_WIDTH-1:0] evt_r;
  reg  [`EVT_WIDTH-1:0] evt_mask_r;

  wire        access;
  wire        wr;
  wire        rd;
  wire        tx_enabled;
  wire        shift_empty;
  wire        load;
  wire        baud_tick;
  wire        last_bit;
  wire        holding_free;
  wire [7:0]  wbyte;
  wire [`EVT_WIDTH-1:0] evt_set;
  reg  [31:0] rdata_nxt;
  reg         decode_ok;
  reg  [31:0] prdata_nxt;
  reg         pready_nxt;
  reg         pslverr_nxt;
  reg  [7:0]  hold_nxt;
  reg         hold_full_nxt;
  reg  [15:0] baud_cnt_nxt;
  reg  [`SHIFT_WIDTH-1:0] shifter_nxt;
  reg  [3:0]  bits_left_nxt;
  reg         tx_out_nxt;
  reg         tx_irq_nxt;
  reg         irq_nxt;
  wire        status_read;
  wire [`EVT_WIDTH-1:0] evt_nxt;

  assign access      = psel & penable & ~pready;
  assign wr          = access & pwrite;
  assign rd          = access & ~pwrite;
  assign wbyte       = pwdata[7:0];
  assign tx_enabled  = tsc_r[`TSC_TRANSMITTER_ON] & rsc_r[`RSC_PORT_ENABLE] & ~tsc_r[`TSC_SYNC_MODE];
  assign shift_empty = (bits_left_r == `BIT_CNT_ZERO);
  assign baud_tick   = (baud_cnt_r == `DIV_ZERO);
  assign last_bit    = (bits_left_r == 4'h1) & baud_tick;
  // load when shifter free, or on the final stop-bit tick
  assign load        = hold_full_r & tx_enabled & (shift_empty | last_bit);
  assign status_read = rd & (paddr == `OFF_IRQ_STATUS);
  assign holding_free = tsc_r[`TSC_TRANSMITTER_ON] & ~hold_full_r;
  assign evt_set     = {last_bit, load};

  // apb: one wait state in the access phase, pready pulses for one cycle
  always @*
  begin
    pready_nxt  = access;
    pslverr_nxt = access & ~decode_ok;
    if (rd)
    begin
      prdata_nxt = rdata_nxt;
    end
    else
    begin
      prdata_nxt = 32'h0000_0000;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
      prdata  <= prdata_nxt;
    end
  end

  // the shifter has no address on purpose
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    decode_ok = 1'b1;
    case (paddr)
      `OFF_TX_STATUS_CONTROL:
      begin
        rdata_nxt[7:0] = {tsc_r[7:2], shift_empty, hold_ninth_r};
      end
      `OFF_RX_STATUS_CONTROL:
      begin
        rdata_nxt[7:0] = rsc_r;
      end
      `OFF_BAUD_CONTROL:
      begin
        rdata_nxt[7:0] = bcn_r;
      end
      `OFF_RECEIVE_DATA:
      begin
        rdata_nxt[7:0] = `RST_BYTE;
      end
      `OFF_TRANSMIT_DATA:
      begin
        rdata_nxt[7:0] = hold_r;
      end
      `OFF_BAUD_DIV_LOW:
      begin
        rdata_nxt[7:0] = div_lo_r;
      end
      `OFF_BAUD_DIV_HIGH:
      begin
        rdata_nxt[7:0] = div_hi_r;
      end
      `OFF_IRQ_CONTROL:
      begin
        rdata_nxt[7:0] = {icn_r[7:4], holding_free, icn_r[2:0]};
      end
      `OFF_IRQ_STATUS:
      begin
        rdata_nxt[`EVT_WIDTH-1:0] = evt_r;
      end
      `OFF_IRQ_MASK:
      begin
        rdata_nxt[`EVT_WIDTH-1:0] = evt_mask_r;
      end
      default:
      begin
        decode_ok = 1'b0;
      end
    endcase
  end

  // control registers; only implemented bits are stored, except transmit status bits 7 and 3
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tsc_r        <= `RST_BYTE;
      rsc_r        <= `RST_BYTE;
      bcn_r        <= `RST_BYTE;
      icn_r        <= `RST_BYTE;
      div_lo_r     <= `RST_BYTE;
      div_hi_r     <= `RST_BYTE;
      evt_mask_r   <= {`EVT_WIDTH{1'b0}};
      hold_ninth_r <= 1'b0;
    end
    else if (wr)
    begin
      case (paddr)
        `OFF_TX_STATUS_CONTROL:
        begin
          tsc_r        <= wbyte & `TSC_WRITE_MASK;
          hold_ninth_r <= wbyte[`TSC_NINTH_DATA_BIT];
        end
        `OFF_RX_STATUS_CONTROL:
        begin
          rsc_r <= wbyte & `RSC_WRITE_MASK;
        end
        `OFF_BAUD_CONTROL:
        begin
          bcn_r <= wbyte & `BCN_WRITE_MASK;
        end
        `OFF_BAUD_DIV_LOW:
        begin
          div_lo_r <= wbyte;
        end
        `OFF_BAUD_DIV_HIGH:
        begin
          div_hi_r <= wbyte;
        end
        `OFF_IRQ_CONTROL:
        begin
          icn_r <= wbyte & `ICN_WRITE_MASK;
        end
        `OFF_IRQ_MASK:
        begin
          evt_mask_r <= pwdata[`EVT_WIDTH-1:0];
        end
        default:
        begin
          tsc_r <= tsc_r;
        end
      endcase
    end
  end

  // holding register; a write while still full overwrites the waiting byte
  always @*
  begin
    hold_nxt      = hold_r;
    hold_full_nxt = hold_full_r;
    if (wr && paddr == `OFF_TRANSMIT_DATA)
    begin
      hold_nxt      = wbyte;
      hold_full_nxt = 1'b1;
    end
    else if (load)
    begin
      hold_full_nxt = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_r      <= `RST_BYTE;
      hold_full_r <= 1'b0;
    end
    else
    begin
      hold_r      <= hold_nxt;
      hold_full_r <= hold_full_nxt;
    end
  end

  // baud generator; divisor arithmetic kept plain: one bit lasts divisor+1 clocks
  always @*
  begin
    if (load || baud_tick)
    begin
      baud_cnt_nxt = {div_hi_r, div_lo_r};
    end
    else
    begin
      baud_cnt_nxt = baud_cnt_r - 16'h0001;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      baud_cnt_r <= `DIV_ZERO;
    end
    else
    begin
      baud_cnt_r <= baud_cnt_nxt;
    end
  end

  // shifter: bit 0 is on the line; stop bit fills from the top
  always @*
  begin
    shifter_nxt   = shifter_r;
    bits_left_nxt = bits_left_r;
    if (load)
    begin
      if (tsc_r[`TSC_NINE_BIT_SELECT])
      begin
        shifter_nxt   = {1'b1, hold_ninth_r, hold_r, 1'b0};
        bits_left_nxt = `FRAME_BITS_9;
      end
      else
      begin
        shifter_nxt   = {2'b11, hold_r, 1'b0};
        bits_left_nxt = `FRAME_BITS_8;
      end
    end
    else if (!shift_empty && baud_tick)
    begin
      shifter_nxt   = {1'b1, shifter_r[`SHIFT_WIDTH-1:1]};
      bits_left_nxt = bits_left_r - 4'h1;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shifter_r   <= {`SHIFT_WIDTH{1'b1}};
      bits_left_r <= `BIT_CNT_ZERO;
    end
    else
    begin
      shifter_r   <= shifter_nxt;
      bits_left_r <= bits_left_nxt;
    end
  end

  // sticky events: read of the status clears, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < `EVT_WIDTH; gi = gi + 1)
    begin : g_evt
      assign evt_nxt[gi] = status_read ? evt_set[gi] : (evt_r[gi] | evt_set[gi]);
    end
  endgenerate

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_r <= {`EVT_WIDTH{1'b0}};
    end
    else
    begin
      evt_r <= evt_nxt;
    end
  end

  // registered outputs; line idles high (inverted when polarity set)
  always @*
  begin
    if (rsc_r[`RSC_PORT_ENABLE])
    begin
      tx_out_nxt = shifter_r[0] ^ bcn_r[`BCN_OUTPUT_POLARITY];
    end
    else
    begin
      tx_out_nxt = ~bcn_r[`BCN_OUTPUT_POLARITY];
    end
    // shift-empty deliberately not a source here
    tx_irq_nxt = holding_free & icn_r[`ICN_TX_IRQ_ENABLE] & icn_r[`ICN_GLOBAL_IRQ_ENABLE]
                 & icn_r[`ICN_PERIPH_IRQ_ENABLE];
    irq_nxt    = |(evt_r & evt_mask_r);
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_out <= 1'b1;
      tx_irq <= 1'b0;
      irq    <= 1'b0;
    end
    else
    begin
      tx_out <= tx_out_nxt;
      tx_irq <= tx_irq_nxt;
      irq    <= irq_nxt;
    end
  end

endmodule

// ---- verif/serial_tx_checker.sv ----
// port assertions for the serial transmitter
`timescale 1ns/100ps
module serial_tx_checker (
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // line and interrupts
  input wire        tx_out,
  input wire        tx_irq,
  input wire        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && !pready;
  a_ready_wait: assert property (acc |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_err_unmapped: assert property (acc && paddr > 12'h024 |=> pslverr) else $error("no slverr");
  a_err_mapped: assert property (acc && paddr < 12'h028 && paddr[1:0] == 2'b00 |=> !pslverr) else $error("bad slverr");
  a_err_ready: assert property (pslverr |-> pready) else $error("lone slverr");
  a_idle_data: assert property (!pready |-> prdata == 32'h0) else $error("prdata leak");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
  // bench runs divisor 1, so every bit lasts two cycles
  a_bit_hold: assert property ($changed(tx_out) |=> $stable(tx_out)) else $error("short bit");
  a_idle_high: assert property ($rose(presetn) |-> tx_out) else $error("idle low");
  cover property (pslverr);
  cover property ($fell(tx_out));
  cover property (irq && tx_irq);
endmodule

// ---- verif/serial_rx_model.sv ----
// far-end receiver decoding frames from the serial line
`timescale 1ns/100ps
module serial_rx_model (
  input  wire        pclk,
  input  wire        line,
  input  wire        inv,
  input  wire        nine,
  input  wire [15:0] div,
  output reg  [8:0]  data,
  output reg         bad,
  output integer     frames
);
  integer i;
  initial
  begin
    frames = 0;
    bad = 1'b0;
    data = 9'h0;
    forever
    begin
      @(negedge pclk);
      if ((line ^ inv) === 1'b0)
      begin
        repeat ((div + 1) / 2) @(negedge pclk);
        // a one-cycle dip (polarity switch) is not a start
        if ((line ^ inv) === 1'b0)
        begin
          for (i = 0; i < (nine ? 9 : 8); i = i + 1)
          begin
            repeat (div + 1) @(negedge pclk);
            data[i] = line ^ inv;
          end
          if (!nine)
            data[8] = 1'b0;
          // data[8] set marks an address byte
          repeat (div + 1) @(negedge pclk);
          if ((line ^ inv) !== 1'b1)
            bad = 1'b1;
          frames = frames + 1;
        end
      end
    end
  end
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the serial transmitter
`timescale 1ns/100ps
`include "serial_tx_defs.vh"
module tb_top;
  reg         pclk;
  reg         presetn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        tx_out;
  wire        tx_irq;
  wire        irq;
  wire [8:0]  rx_data;
  wire        rx_bad;
  integer     frames;
  integer     n_fail;
  integer     n_tests;
  integer     cycles;
  reg         inv;
  reg         nine;
  reg  [31:0] rv;
  reg         ev;
  async_serial_transmitter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_out(tx_out),
    .tx_irq(tx_irq), .irq(irq));
  serial_rx_model rx (.pclk(pclk), .line(tx_out), .inv(inv), .nine(nine), .div(16'h0001), .data(rx_data),
    .bad(rx_bad), .frames(frames));
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  task print_verdict;
  begin
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task rd(input [11:0] a, input [31:0] exp);
  begin
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task wait_rx(input integer n, input [31:0] exp);
  begin
    while (frames < n)
      @(posedge pclk);
    chk({23'h0, rx_data}, exp);
  end
  endtask
  initial
  begin
    {n_fail, n_tests, cycles} = 96'h0;
    {presetn, psel, penable, pwrite, paddr, pwdata, inv, nine} = 50'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFF_TX_STATUS_CONTROL, 32'h02);
    rd(12'h030, 32'h0);
    chk(ev, 1'b1);
    $display("reset test done");
    wr(`OFF_BAUD_DIV_LOW, 32'h01);
    wr(`OFF_BAUD_DIV_HIGH, 32'h00);
    wr(`OFF_RX_STATUS_CONTROL, 32'h80);
    wr(`OFF_IRQ_CONTROL, 32'h07);
    wr(`OFF_IRQ_MASK, 32'h03);
    wr(`OFF_TX_STATUS_CONTROL, 32'h20);
    rd(`OFF_IRQ_CONTROL, 32'h0F);
    chk(tx_irq, 1'b1);
    chk(irq, 1'b0);
    $display("enable test done");
    // second write lands while the first character shifts
    wr(`OFF_TRANSMIT_DATA, 32'hA5);
    wr(`OFF_TRANSMIT_DATA, 32'hC3);
    rd(`OFF_IRQ_CONTROL, 32'h07);
    chk(tx_irq, 1'b0);
    rd(`OFF_TX_STATUS_CONTROL, 32'h20);
    wait_rx(1, 32'hA5);
    wait_rx(2, 32'hC3);
    repeat (4) @(posedge pclk);
    rd(`OFF_TX_STATUS_CONTROL, 32'h22);
    chk(irq, 1'b1);
    rd(`OFF_IRQ_STATUS, 32'h03);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    $display("stream test done");
    nine <= 1'b1;
    wr(`OFF_TX_STATUS_CONTROL, 32'h61);
    wr(`OFF_TRANSMIT_DATA, 32'h3C);
    wait_rx(3, 32'h13C);
    $display("nine bit test done");
    wr(`OFF_BAUD_CONTROL, 32'h10);
    inv <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(tx_out, 1'b0);
    wr(`OFF_TX_STATUS_CONTROL, 32'h60);
    wr(`OFF_TRANSMIT_DATA, 32'h5A);
    wait_rx(4, 32'h05A);
    chk(rx_bad, 1'b0);
    $display("polarity test done");
    print_verdict;
  end
endmodule
bind async_serial_transmitter serial_tx_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_out(tx_out), .tx_irq(tx_irq), .irq(irq));
